// ===== rtl/eabp_top.sv
// external address/data bus phasing engine with an AXI4-Lite register port
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module eabp_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire eabp_pkg::eabp_axil_req_t axi_req,
  output eabp_pkg::eabp_axil_rsp_t axi_rsp,
  input wire logic [15:0] int_mem_rdata,
  input wire logic hold_req,
  input wire logic tristate_test,
  input wire logic show_read_strap_n,
  input wire logic byte_high_address_enable_strap,
  input wire logic [15:0] mux_addr_data_lanes_i,
  output logic [15:0] mux_addr_data_lanes_o,
  output logic [15:0] mux_addr_data_lanes_oe,
  input wire logic [7:0] high_address_only_lanes_i,
  output logic [7:0] high_address_only_lanes_o,
  output logic high_address_only_lanes_oe,
  output logic [19:0] nonmux_address_outputs_o,
  output logic nonmux_address_outputs_oe,
  output logic addr_latch_strobe_o,
  output logic addr_latch_strobe_oe,
  output logic bus_clock_out,
  output logic low_byte_write_strobe_n_o,
  output logic high_byte_write_strobe_n_o,
  output logic write_strobes_oe,
  output logic status_six_out,
  output logic upper_lane_indicator_n
);
  import eabp_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_PRE, S_T1, S_T2, S_T3, S_T4
  } eabp_state_t;

  logic half_tick;
  logic [SYNC_W-1:0] sync_q;
  logic [15:0] lanes_q;
  logic [7:0] ao_q;
  logic aden_pin_q;
  logic sr_pin_q;
  logic hold_q;

  eabp_phase_div u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .half_tick(half_tick),
    .bus_clk(bus_clock_out)
  );

  eabp_pin_sync #(.W(SYNC_W)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({hold_req, show_read_strap_n, byte_high_address_enable_strap,
        high_address_only_lanes_i, mux_addr_data_lanes_i}),
    .q(sync_q)
  );

  assign {hold_q, sr_pin_q, aden_pin_q, ao_q, lanes_q} = sync_q;

  // strap capture after reset release
  logic [1:0] strap_cnt;
  logic [1:0] next_strap_cnt;
  logic strap_done;
  logic next_strap_done;
  logic aden_mode;
  logic next_aden_mode;
  logic sr_strap;
  logic next_sr_strap;
  logic [15:0] rst_cfg;
  logic [15:0] next_rst_cfg;
  logic [31:0] ctrl;

  always_comb
  begin
    next_strap_cnt = strap_cnt;
    next_strap_done = strap_done;
    next_aden_mode = aden_mode;
    next_sr_strap = sr_strap;
    next_rst_cfg = rst_cfg;
    if (!strap_done)
    begin
      next_strap_cnt = strap_cnt + 2'h1;
      if (strap_cnt == 2'(STRAP_SAMPLE_CYC))
      begin
        next_strap_done = 1'b1;
        next_aden_mode = aden_pin_q;
        next_sr_strap = ~sr_pin_q;
        // narrow variant takes its upper half from the address-only lanes
        next_rst_cfg = ctrl[CTRL_NARROW] ? {ao_q, lanes_q[7:0]} : lanes_q;
      end
    end
  end

  // pull-up default: address disable honoured until the strap is seen
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      strap_cnt <= 2'h0;
      strap_done <= 1'b0;
      aden_mode <= 1'b1;
      sr_strap <= 1'b0;
      rst_cfg <= 16'h0000;
    end
    else
    begin
      strap_cnt <= next_strap_cnt;
      strap_done <= next_strap_done;
      aden_mode <= next_aden_mode;
      sr_strap <= next_sr_strap;
      rst_cfg <= next_rst_cfg;
    end
  end

  // register file and AXI4-Lite slave
  logic [31:0] addr_reg;
  logic [31:0] wdata_reg;
  logic pend;
  logic pend_write;
  logic aw_full;
  logic w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] next_ctrl;
  logic [31:0] next_addr_reg;
  logic [31:0] next_wdata_reg;
  logic next_pend;
  logic next_pend_write;
  logic next_aw_full;
  logic next_w_full;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic bvalid;
  logic next_bvalid;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  logic rvalid;
  logic next_rvalid;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0] rresp;
  logic [1:0] next_rresp;
  logic fsm_start;
  logic busy;
  logic pio_grant;
  logic [15:0] rd_capt;
  eabp_state_t state;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[b*8 +: 8] = nw[b*8 +: 8];
    return r;
  endfunction : merge

  assign busy = pend | (state != S_IDLE);
  // status pins keep normal use when the strap came up low
  assign pio_grant = ctrl[CTRL_PIO_REQ] & aden_mode;

  always_comb
  begin
    next_ctrl = ctrl;
    next_addr_reg = addr_reg;
    next_wdata_reg = wdata_reg;
    next_pend = fsm_start ? 1'b0 : pend;
    next_pend_write = pend_write;
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    axi_rsp.awready = !aw_full && !bvalid;
    axi_rsp.wready = !w_full && !bvalid;
    axi_rsp.arready = !rvalid;
    axi_rsp.bvalid = bvalid;
    axi_rsp.bresp = bresp;
    axi_rsp.rvalid = rvalid;
    axi_rsp.rdata = rdata;
    axi_rsp.rresp = rresp;
    if (axi_req.awvalid && axi_rsp.awready)
    begin
      next_aw_full = 1'b1;
      next_aw_addr = axi_req.awaddr[7:0];
    end
    if (axi_req.wvalid && axi_rsp.wready)
    begin
      next_w_full = 1'b1;
      next_w_data = axi_req.wdata;
      next_w_strb = axi_req.wstrb;
    end
    if (aw_full && w_full && !bvalid)
    begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      case (aw_addr)
        OFS_CTRL: next_ctrl = merge(ctrl, w_data, w_strb);
        OFS_ADDR: next_addr_reg = merge(addr_reg, w_data, w_strb);
        OFS_WDATA: next_wdata_reg = merge(wdata_reg, w_data, w_strb);
        OFS_CMD:
        begin
          // a command while a cycle is under way is dropped
          if (!busy && w_strb[0])
          begin
            next_pend = 1'b1;
            next_pend_write = w_data[CMD_WRITE];
          end
        end
        OFS_STATUS, OFS_RDATA, OFS_RSTCFG: next_bresp = RESP_OKAY;
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    if (bvalid && axi_req.bready)
      next_bvalid = 1'b0;
    if (rvalid && axi_req.rready)
      next_rvalid = 1'b0;
    if (axi_req.arvalid && axi_rsp.arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = 32'h0000_0000;
      case (axi_req.araddr[7:0])
        OFS_CTRL: next_rdata = ctrl;
        OFS_ADDR: next_rdata = addr_reg;
        OFS_WDATA: next_rdata = wdata_reg;
        OFS_CMD: next_rdata = {31'h0, pend_write};
        OFS_STATUS:
        begin
          next_rdata[ST_BUSY] = busy;
          next_rdata[ST_ADEN] = aden_mode;
          next_rdata[ST_SR_STRAP] = sr_strap;
          next_rdata[ST_PIO_GRANT] = pio_grant;
          next_rdata[ST_HOLD] = hold_q;
        end
        OFS_RDATA: next_rdata = {16'h0000, rd_capt};
        OFS_RSTCFG: next_rdata = {16'h0000, rst_cfg};
        default: next_rresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= CTRL_RST;
      addr_reg <= ADDR_RST;
      wdata_reg <= WDATA_RST;
      pend <= 1'b0;
      pend_write <= 1'b0;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end
    else
    begin
      ctrl <= next_ctrl;
      addr_reg <= next_addr_reg;
      wdata_reg <= next_wdata_reg;
      pend <= next_pend;
      pend_write <= next_pend_write;
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // bus cycle sequencer, stepped on half bus clock ticks; S_PRE lasts one, S_T1 to S_T4 two each
  eabp_state_t next_state;
  logic half;
  logic next_half;
  logic [31:0] cyc_addr;
  logic [31:0] next_cyc_addr;
  logic [31:0] cyc_wd;
  logic [31:0] next_cyc_wd;
  logic cyc_write;
  logic next_cyc_write;
  logic cyc_narrow;
  logic next_cyc_narrow;
  logic [15:0] next_rd_capt;
  logic show_rd;
  logic addr_on;

  // new cycles wait out a hold; a cycle in flight completes
  assign fsm_start = half_tick && state == S_IDLE && pend && !hold_q;
  assign show_rd = !cyc_write && cyc_addr[ADDR_INTERNAL] &&
                   (sr_strap || ctrl[CTRL_SR]);

  always_comb
  begin
    addr_on = 1'b1;
    if (aden_mode)
    begin
      if (cyc_addr[ADDR_REGION_LSB +: 2] == REGION_LOWER && ctrl[CTRL_DA_LO])
        addr_on = 1'b0;
      if (cyc_addr[ADDR_REGION_LSB +: 2] == REGION_UPPER && ctrl[CTRL_DA_UP])
        addr_on = 1'b0;
    end
  end

  always_comb
  begin
    next_state = state;
    next_half = half;
    next_cyc_addr = cyc_addr;
    next_cyc_wd = cyc_wd;
    next_cyc_write = cyc_write;
    next_cyc_narrow = cyc_narrow;
    next_rd_capt = rd_capt;
    if (half_tick)
    begin
      next_half = ~half;
      case (state)
        S_IDLE:
        begin
          next_half = 1'b0;
          if (fsm_start)
          begin
            next_state = S_PRE;
            next_cyc_addr = addr_reg;
            next_cyc_wd = wdata_reg;
            next_cyc_write = pend_write;
            next_cyc_narrow = ctrl[CTRL_NARROW];
          end
        end
        S_PRE:
        begin
          next_state = S_T1;
          next_half = 1'b0;
        end
        S_T1: if (half) next_state = S_T2;
        S_T2: if (half) next_state = S_T3;
        S_T3:
        begin
          if (half)
          begin
            next_state = S_T4;
            if (!cyc_write)
            begin
              next_rd_capt = show_rd ? int_mem_rdata : lanes_q;
              if (cyc_narrow)
                next_rd_capt[15:8] = 8'h00;
            end
          end
        end
        S_T4: if (half) next_state = S_IDLE;
        default: next_state = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= S_IDLE;
      half <= 1'b0;
      cyc_addr <= ADDR_RST;
      cyc_wd <= WDATA_RST;
      cyc_write <= 1'b0;
      cyc_narrow <= 1'b0;
      rd_capt <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      half <= next_half;
      cyc_addr <= next_cyc_addr;
      cyc_wd <= next_cyc_wd;
      cyc_write <= next_cyc_write;
      cyc_narrow <= next_cyc_narrow;
      rd_capt <= next_rd_capt;
    end
  end

  // pin drivers, registered; all enables fall in reset, and all but addr_latch_strobe_oe (set by tristate_test) on hold once idle
  logic [15:0] n_lo;
  logic [15:0] n_loe;
  logic [7:0] n_ao;
  logic n_aoe;
  logic [19:0] n_na;
  logic n_naoe;
  logic n_ale;
  logic n_wlb;
  logic n_whb;
  logic n_wsoe;
  logic n_s6;
  logic n_uzi;
  logic in_cyc;
  logic data_ph;
  logic lo_be;
  logic hi_be;

  always_comb
  begin
    in_cyc = state != S_IDLE && state != S_PRE;
    data_ph = state == S_T2 || state == S_T3 || state == S_T4;
    lo_be = cyc_wd[WDATA_BE_LSB];
    hi_be = cyc_wd[WDATA_BE_LSB + 1] && !cyc_narrow;
    n_lo = 16'h0000;
    n_loe = 16'h0000;
    n_ao = cyc_addr[15:8];
    n_aoe = 1'b0;
    n_na = cyc_addr[19:0];
    n_naoe = 1'b0;
    n_ale = 1'b0;
    n_wlb = 1'b1;
    n_whb = 1'b1;
    n_wsoe = 1'b0;
    n_s6 = pio_grant ? ctrl[CTRL_PIO_S6] : 1'b0;
    n_uzi = pio_grant ? ctrl[CTRL_PIO_UZI] : !(in_cyc && hi_be);
    if (!(hold_q && state == S_IDLE))
    begin
      n_wsoe = 1'b1;
      n_naoe = state != S_IDLE;
      if (in_cyc && cyc_narrow)
        n_aoe = 1'b1;
      if (state == S_T1 && addr_on)
      begin
        n_lo[7:0] = cyc_addr[7:0];
        n_loe[7:0] = 8'hff;
        if (!cyc_narrow)
        begin
          n_lo[15:8] = cyc_addr[15:8];
          n_loe[15:8] = 8'hff;
        end
        n_ale = !half;
      end
      if (data_ph && cyc_write)
      begin
        n_lo = cyc_wd[15:0];
        n_loe[7:0] = {8{lo_be}};
        n_loe[15:8] = {8{hi_be}};
        n_wlb = !(lo_be && state != S_T4);
        n_whb = !(hi_be && state != S_T4);
      end
      if ((state == S_T3 || state == S_T4) && show_rd)
      begin
        n_lo = int_mem_rdata;
        n_loe[7:0] = 8'hff;
        n_loe[15:8] = {8{!cyc_narrow}};
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mux_addr_data_lanes_o <= 16'h0000;
      mux_addr_data_lanes_oe <= 16'h0000;
      high_address_only_lanes_o <= 8'h00;
      high_address_only_lanes_oe <= 1'b0;
      nonmux_address_outputs_o <= 20'h00000;
      nonmux_address_outputs_oe <= 1'b0;
      addr_latch_strobe_o <= 1'b0;
      addr_latch_strobe_oe <= 1'b0;
      low_byte_write_strobe_n_o <= 1'b1;
      high_byte_write_strobe_n_o <= 1'b1;
      write_strobes_oe <= 1'b0;
      status_six_out <= 1'b0;
      upper_lane_indicator_n <= 1'b1;
    end
    else
    begin
      mux_addr_data_lanes_o <= n_lo;
      mux_addr_data_lanes_oe <= n_loe;
      high_address_only_lanes_o <= n_ao;
      high_address_only_lanes_oe <= n_aoe;
      nonmux_address_outputs_o <= n_na;
      nonmux_address_outputs_oe <= n_naoe;
      addr_latch_strobe_o <= n_ale;
      addr_latch_strobe_oe <= !tristate_test;
      low_byte_write_strobe_n_o <= n_wlb;
      high_byte_write_strobe_n_o <= n_whb;
      write_strobes_oe <= n_wsoe;
      status_six_out <= n_s6;
      upper_lane_indicator_n <= n_uzi;
    end
  end
endmodule : eabp_top

// ===== rtl/eabp_pkg.sv
// constants, register map and bus carriers for the external bus phasing block
package eabp_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int BUS_HALF_NS = 20;
  localparam int HALF_CYC = (BUS_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_CNT_W = $clog2(HALF_CYC) + 1;
  // crystal clock equals aclk here
  localparam int STRAP_WIN_XTAL = 3;
  localparam int STRAP_SAMPLE_CYC = STRAP_WIN_XTAL - 1;
  localparam int SYNC_W = 27;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_RDATA = 8'h14;
  localparam logic [7:0] OFS_RSTCFG = 8'h18;

  localparam int CTRL_SR = 0;
  localparam int CTRL_DA_LO = 1;
  localparam int CTRL_DA_UP = 2;
  localparam int CTRL_PIO_REQ = 3;
  localparam int CTRL_PIO_S6 = 4;
  localparam int CTRL_PIO_UZI = 5;
  localparam int CTRL_NARROW = 6;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] WDATA_RST = 32'h0003_0000;

  localparam int ADDR_REGION_LSB = 20;
  localparam int ADDR_INTERNAL = 22;
  localparam int WDATA_BE_LSB = 16;
  localparam int CMD_WRITE = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_ADEN = 1;
  localparam int ST_SR_STRAP = 2;
  localparam int ST_PIO_GRANT = 3;
  localparam int ST_HOLD = 4;

  localparam logic [1:0] REGION_LOWER = 2'h1;
  localparam logic [1:0] REGION_UPPER = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } eabp_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } eabp_axil_rsp_t;
endpackage : eabp_pkg

// ===== rtl/eabp_pin_sync.sv
// three-stage pin synchroniser that passes a bit once stages two and three agree
`timescale 1ns/1ns
module eabp_pin_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // data stages carry no reset so a strap is still seen right after release
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_q;

  always_ff @(posedge aclk)
  begin
    s1 <= d;
    s2 <= s1;
    s3 <= s2;
  end

  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_comb
    begin
      next_q[i] = q[i];
      if (s2[i] == s3[i])
        next_q[i] = s3[i];
    end

    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        q[i] <= 1'b0;
      else
        q[i] <= next_q[i];
    end
  end
endmodule : eabp_pin_sync

// ===== rtl/eabp_phase_div.sv
// bus clock divider: half-period enable pulse and the bus clock level
`timescale 1ns/1ns
module eabp_phase_div
  import eabp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  output logic half_tick,
  output logic bus_clk
);
  logic [HALF_CNT_W-1:0] cnt;
  logic [HALF_CNT_W-1:0] next_cnt;
  logic next_bus_clk;

  always_comb
  begin
    half_tick = (cnt == HALF_CNT_W'(HALF_CYC - 1));
    next_cnt = half_tick ? '0 : cnt + 1'b1;
    next_bus_clk = half_tick ? ~bus_clk : bus_clk;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt <= '0;
      bus_clk <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      bus_clk <= next_bus_clk;
    end
  end
endmodule : eabp_phase_div

// ===== tb/eabp_top_props.sv
// pin-level assertions for the bus phasing block
`timescale 1ns/1ns
module eabp_top_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tristate_test,
  input wire logic [15:0] mux_addr_data_lanes_o,
  input wire logic [15:0] mux_addr_data_lanes_oe,
  input wire logic [7:0] high_address_only_lanes_o,
  input wire logic high_address_only_lanes_oe,
  input wire logic [19:0] nonmux_address_outputs_o,
  input wire logic nonmux_address_outputs_oe,
  input wire logic addr_latch_strobe_o,
  input wire logic addr_latch_strobe_oe,
  input wire logic bus_clock_out,
  input wire logic low_byte_write_strobe_n_o,
  input wire logic high_byte_write_strobe_n_o
);
  wire [15:0] mo = mux_addr_data_lanes_o;
  wire [15:0] moe = mux_addr_data_lanes_oe;
  wire [19:0] na = nonmux_address_outputs_o;
  wire na_oe = nonmux_address_outputs_oe;
  wire ale = addr_latch_strobe_o;
  wire lo_n = low_byte_write_strobe_n_o;
  wire hi_n = high_byte_write_strobe_n_o;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst_float;
    $rose(aresetn) |-> !na_oe && moe == 16'h0 && !high_address_only_lanes_oe;
  endproperty
  a_rst_float: assert property (p_rst_float)
    else $error("pins driven right after reset");
  property p_lead;
    $rose(ale) |-> na_oe && $past(na_oe) && mo[7:0] == na[7:0];
  endproperty
  a_lead: assert property (p_lead)
    else $error("low address byte or lead wrong");
  property p_hi_addr;
    $rose(ale) && moe[15:8] == 8'hff |-> mo[15:8] == na[15:8];
  endproperty
  a_hi_addr: assert property (p_hi_addr)
    else $error("high address byte wrong");
  property p_ao;
    $rose(ale) && high_address_only_lanes_oe
      |-> high_address_only_lanes_o == na[15:8];
  endproperty
  a_ao: assert property (p_ao)
    else $error("address-only lanes wrong");
  property p_ale;
    $rose(ale) |=> ale ##1 !ale && moe[7:0] == 8'hff && $stable(mo[7:0]);
  endproperty
  a_ale: assert property (p_ale)
    else $error("latch strobe width or address hold wrong");
  property p_tst;
    tristate_test |=> !addr_latch_strobe_oe;
  endproperty
  a_tst: assert property (p_tst)
    else $error("latch strobe driven in test mode");
  property p_lo_float;
    lo_n && !hi_n |-> moe[7:0] == 8'h00;
  endproperty
  a_lo_float: assert property (p_lo_float)
    else $error("low lanes driven without strobe");
  property p_hi_float;
    !lo_n && hi_n |-> moe[15:8] == 8'h00;
  endproperty
  a_hi_float: assert property (p_hi_float)
    else $error("high lanes driven without strobe");
  property p_wlen;
    $fell(lo_n) |-> (!lo_n && moe[7:0] == 8'hff)[*8] ##1 lo_n;
  endproperty
  a_wlen: assert property (p_wlen)
    else $error("write data phase length wrong");
  property p_t4;
    $rose(lo_n) |-> (moe[7:0] == 8'hff)[*4] ##1 moe[7:0] == 8'h00;
  endproperty
  a_t4: assert property (p_t4)
    else $error("write data not held through t4");
  property p_bclk;
    $rose(bus_clock_out) |=> bus_clock_out ##1 !bus_clock_out;
  endproperty
  a_bclk: assert property (p_bclk)
    else $error("bus clock half period wrong");
endmodule : eabp_top_props

bind eabp_top eabp_top_props i_props (.aclk, .aresetn, .tristate_test,
  .mux_addr_data_lanes_o, .mux_addr_data_lanes_oe,
  .high_address_only_lanes_o, .high_address_only_lanes_oe,
  .nonmux_address_outputs_o, .nonmux_address_outputs_oe,
  .addr_latch_strobe_o, .addr_latch_strobe_oe, .bus_clock_out,
  .low_byte_write_strobe_n_o, .high_byte_write_strobe_n_o);

// ===== tb/eabp_ext_mem.sv
// external memory hanging on the multiplexed bus
`timescale 1ns/1ns
module eabp_ext_mem #(
  parameter int LAT = 1
) (
  input wire logic aclk,
  input wire logic [15:0] lanes,
  input wire logic ale,
  input wire logic [19:0] na,
  input wire logic na_oe,
  input wire logic lo_n,
  input wire logic hi_n,
  output logic [15:0] drv
);
  logic [15:0] mem [16];
  logic [3:0] a = '0;
  logic [15:0] last = '0;
  logic ale_q = 1'b0;
  logic lo_q = 1'b1;
  logic hi_q = 1'b1;
  int cnt = 0;
  always @(posedge aclk)
  begin
    ale_q <= ale;
    lo_q <= lo_n;
    hi_q <= hi_n;
    cnt <= na_oe ? cnt + 1 : 0;
    // suppressed address phase: decode from the nonmux pins
    if (na_oe && cnt == 0) a <= na[3:0];
    if (ale_q && !ale) a <= lanes[3:0];
    if (lo_n && !lo_q) mem[a][7:0] <= lanes[7:0];
    if (hi_n && !hi_q) mem[a][15:8] <= lanes[15:8];
    // LAT delays data but it still settles well before t3 ends
    if (na_oe && cnt >= 5 + LAT) last <= mem[a];
    else last <= ~last;
  end
  assign drv = last;
endmodule : eabp_ext_mem

// ===== tb/tb_eabp_top.sv
// bench for the external bus phasing block
`timescale 1ns/1ns
module tb_eabp_top;
  import eabp_pkg::*;
  localparam logic [15:0] CFG = 16'h5a3c;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  eabp_axil_req_t req = '0;
  eabp_axil_rsp_t rsp;
  logic [15:0] imd = '0;
  logic hold = 1'b0;
  logic tst = 1'b0;
  logic aden = 1'b1;
  logic srn = 1'b1;
  logic cfg_on = 1'b1;
  logic [15:0] mo, moe, drv, lanes;
  logic [7:0] hao;
  logic [19:0] na;
  logic hao_oe, na_oe, ale, ale_oe, lo_n, hi_n, s6, wsoe, upper_lane_indicator;
  logic ale_q = 1'b0;
  logic sr_seen = 1'b0;
  logic [31:0] d;
  logic [1:0] r;
  int err_total = 0;
  int checks = 0;
  int ale_n = 0;
  int n;
  // undriven lanes carry the strap pattern around reset
  assign lanes = (moe & mo) | (~moe & (cfg_on ? CFG : drv));
  initial forever #5 aclk = ~aclk;
  eabp_top i_dut (.aclk, .aresetn, .axi_req(req), .axi_rsp(rsp),
    .int_mem_rdata(imd), .hold_req(hold), .tristate_test(tst),
    .show_read_strap_n(srn), .byte_high_address_enable_strap(aden),
    .mux_addr_data_lanes_i(lanes), .mux_addr_data_lanes_o(mo),
    .mux_addr_data_lanes_oe(moe), .high_address_only_lanes_i(CFG[15:8]),
    .high_address_only_lanes_o(hao), .high_address_only_lanes_oe(hao_oe),
    .nonmux_address_outputs_o(na), .nonmux_address_outputs_oe(na_oe),
    .addr_latch_strobe_o(ale), .addr_latch_strobe_oe(ale_oe),
    .bus_clock_out(), .low_byte_write_strobe_n_o(lo_n),
    .high_byte_write_strobe_n_o(hi_n), .write_strobes_oe(wsoe),
    .status_six_out(s6), .upper_lane_indicator_n(upper_lane_indicator));
  eabp_ext_mem i_mem (.aclk, .lanes, .ale, .na, .na_oe, .lo_n, .hi_n,
    .drv);
  always @(posedge aclk)
  begin
    ale_q <= ale;
    if (ale && !ale_q) ale_n++;
    if (moe == 16'hffff && mo == 16'h7e81) sr_seen <= 1'b1;
  end
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    req.awaddr <= {24'h0, a};
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge aclk);
    req.araddr <= {24'h0, a};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd
  task idle;
    d = 32'h1;
    while (d[ST_BUSY]) rd(OFS_STATUS);
  endtask : idle
  task cyc(input logic [31:0] c);
    wr(OFS_CMD, c);
    idle();
  endtask : cyc
  task rst(input logic s);
    aresetn <= 1'b0;
    cfg_on <= 1'b1;
    aden <= s;
    srn <= s;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (5) @(posedge aclk);
    cfg_on <= 1'b0;
  endtask : rst
  task summarize;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (20000) @(posedge aclk);
    err_total++;
    summarize();
  end
  initial
  begin
    rst(1'b1);
    rd(OFS_RSTCFG);
    chk("rstcfg", {16'h0, CFG}, d);
    rd(OFS_STATUS);
    chk("aden", 32'h1, {31'h0, d[ST_ADEN]});
    rd(OFS_WDATA);
    chk("wdata", WDATA_RST, d);
    rd(8'h40);
    chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
    $display("test reset done");
    wr(OFS_ADDR, 32'h00001234);
    wr(OFS_WDATA, 32'h0003beef);
    cyc(32'h1);
    chk("mem", 32'hbeef, {16'h0, i_mem.mem[4]});
    wr(OFS_WDATA, 32'h00011155);
    cyc(32'h1);
    cyc(32'h0);
    rd(OFS_RDATA);
    chk("low only", 32'hbe55, d);
    // high byte only: low lanes must float while its strobe is negated
    wr(OFS_WDATA, 32'h0002a1ff);
    cyc(32'h1);
    wr(OFS_CTRL, 32'h40);
    cyc(32'h0);
    rd(OFS_RDATA);
    chk("narrow", 32'h55, d);
    $display("test data done");
    wr(OFS_CTRL, 32'h1a);
    wr(OFS_ADDR, 32'h00101234);
    n = ale_n;
    cyc(32'h0);
    chk("no ale", n, ale_n);
    rd(OFS_RDATA);
    chk("no addr rd", 32'ha155, d);
    chk("pio", 32'h1, {30'h0, upper_lane_indicator, s6});
    imd <= 16'h7e81;
    wr(OFS_CTRL, 32'h1);
    wr(OFS_ADDR, 32'h00400004);
    cyc(32'h0);
    chk("show seen", 32'h1, {31'h0, sr_seen});
    rd(OFS_RDATA);
    chk("show data", 32'h7e81, d);
    $display("test modes done");
    hold <= 1'b1;
    tst <= 1'b1;
    wr(OFS_ADDR, 32'h00001234);
    wr(OFS_CMD, 32'h1);
    repeat (30) @(posedge aclk);
    chk("hold", 32'h0, {14'h0, wsoe, na_oe, moe});
    chk("ale oe", 32'h0, {31'h0, ale_oe});
    rd(OFS_STATUS);
    chk("busy", 32'h1, {31'h0, d[ST_BUSY]});
    hold <= 1'b0;
    idle();
    tst <= 1'b0;
    $display("test hold done");
    rst(1'b0);
    wr(OFS_CTRL, 32'h1a);
    wr(OFS_ADDR, 32'h00101234);
    n = ale_n + 1;
    cyc(32'h0);
    chk("ale kept", n, ale_n);
    rd(OFS_STATUS);
    chk("strap low", 32'h0, {30'h0, d[ST_PIO_GRANT], d[ST_ADEN]});
    chk("sr strap", 32'h1, {31'h0, d[ST_SR_STRAP]});
    chk("pio refused", 32'h2, {30'h0, upper_lane_indicator, s6});
    $display("test strap done");
    summarize();
  end
endmodule : tb_eabp_top
